// ===== include/clpr_pkg.sv
// Overview of operation
// - Encoder scale supports binary 2^16 and decimal 10000 fractional denominators.
// - Electrical angle path uses only binary scaling, never decimal.
// - Load angle limit is programmable, values above 90 degrees allowed.
// - After reset the sequencer microstep angle index is all zero.
// - Error equals encoder position minus sequencer position; drives correction velocity.
// - Velocity is sum of P, I, D terms until error is inside deadband.
// - Zero derivative gain gives PI; zero integral gain too gives P plus the frozen integral sum.
// - Host velocity offset is added to the regulator output velocity.
// - Current clipping amount is readable.
// - Integral grows by gain times error each step, clipped to the limit.
// - Integration advances at system clock divided by 128.
// - Derivative time base set by a programmable clock divider.
// - Current position error is readable at any time.
// - Regulator update rate is programmable up to about 100 kHz.
// - Each quadrature change adds or subtracts the 16.16 encoder constant.
// - Deviation warning raised when error magnitude exceeds distance, regulator enabled.
package clpr_pkg;

   // -----------------------------------------------------------------
   // Widths, reset values and timing
   // -----------------------------------------------------------------
   localparam int          POS_W          = 32;
   localparam int          FRAC_W         = 16;
   localparam int          ANGLE_W        = 13;
   localparam int          INT_DIV        = 128;
   localparam int          INT_DIV_W      = 7;
   localparam logic [15:0] DEC_DENOM      = 16'h2710;
   localparam logic [15:0] BIN_DENOM_M1   = 16'hffff;
   localparam logic [31:0] POS_RESET      = 32'h0000_0000;
   localparam int          ISUM_W         = 48;
   localparam int          ACC_W          = 40;
   localparam logic [31:0] VEL_MAX        = 32'h7fff_ffff;

   typedef struct packed {
      logic        enable;
      logic        decimal_mode;
      logic [31:0] enc_const;
      logic [15:0] p_gain;
      logic [15:0] i_gain;
      logic [15:0] d_gain;
      logic [31:0] i_clip;
      logic [31:0] tolerance;
      logic [15:0] update_div;
      logic [15:0] d_clk_div;
      logic [31:0] host_velocity_offset;
      logic [31:0] warn_dist;
      logic [31:0] vector_count_scale;
      logic [ANGLE_W-1:0] load_angle_limit;
   } clpr_cfg_s;

   typedef struct packed {
      logic [31:0] error;
      logic [31:0] velocity;
      logic [31:0] clipping_amount;
      logic [31:0] enc_position;
      logic        deviation_warn;
   } clpr_stat_s;

endpackage

// ===== verilog/clpr_quad_decoder.sv
`timescale 1ns/100ps
module clpr_quad_decoder (
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   input  wire logic enc_a_i,
   input  wire logic enc_b_i,
   output logic      step_o,
   output logic      dir_o
);
   // Two-stage synchronisers; only stage two feeds the decoder.
   logic [1:0] a_sync_q, a_sync_d;
   logic [1:0] b_sync_q, b_sync_d;
   logic [1:0] prev_q, prev_d;
   logic       step_q, step_d;
   logic       dir_q, dir_d;
   logic [1:0] cur;

   always_comb begin
      a_sync_d = {a_sync_q[0], enc_a_i};
      b_sync_d = {b_sync_q[0], enc_b_i};
      cur      = {a_sync_q[1], b_sync_q[1]};
      prev_d   = cur;
      step_d   = 1'b0;
      dir_d    = dir_q;
      if (cur != prev_q && (cur ^ prev_q) != 2'h3) begin
         step_d = 1'b1;
         // Forward when new A equals old B.
         dir_d  = (cur[1] ^ prev_q[0]) == 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         a_sync_q <= 2'h0;
         b_sync_q <= 2'h0;
         prev_q   <= 2'h0;
         step_q   <= 1'b0;
         dir_q    <= 1'b0;
      end else begin
         a_sync_q <= a_sync_d;
         b_sync_q <= b_sync_d;
         prev_q   <= prev_d;
         step_q   <= step_d;
         dir_q    <= dir_d;
      end
   end

   assign step_o = step_q;
   assign dir_o  = dir_q;
endmodule

// ===== verilog/clpr_regulator.sv
`timescale 1ns/100ps
module clpr_regulator (
   input  wire logic                                clock_i,
   input  wire logic                                rst_n_i,
   input  wire logic                                enc_a_i,
   input  wire logic                                enc_b_i,
   input  wire clpr_pkg::clpr_cfg_s                 cfg_i,
   input  wire logic [31:0]                         seq_position_i,
   input  wire logic                                seq_step_i,
   input  wire logic                                seq_dir_i,
   input  wire logic                                angle_wr_i,
   input  wire logic [31:0]                         angle_wdata_i,
   output clpr_pkg::clpr_stat_s                     stat_o,
   output logic [31:0]                              electrical_angle_position_o,
   output logic [clpr_pkg::ANGLE_W-1:0]             microstep_index_o,
   output logic                                     load_angle_exceeded_o
);
   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   localparam int ACC_W_L   = clpr_pkg::ACC_W;
   localparam int ANGLE_W_L = clpr_pkg::ANGLE_W;

   function automatic logic [31:0] abs32(input logic [31:0] v);
      abs32 = v[31] ? 32'(-v) : v;
   endfunction

   // Saturation keeps the velocity inside the signed 32-bit range; the excess is reported as clipping.
   function automatic logic [31:0] sat32(input logic signed [ACC_W_L-1:0] v);
      if (v > $signed({{(ACC_W_L-32){1'b0}}, clpr_pkg::VEL_MAX}))
         sat32 = clpr_pkg::VEL_MAX;
      else if (v < -$signed({{(ACC_W_L-32){1'b0}}, clpr_pkg::VEL_MAX}))
         sat32 = 32'(-clpr_pkg::VEL_MAX);
      else
         sat32 = v[31:0];
   endfunction

   // The decoder owns the pin synchronisers, so nothing here reads the raw pins.

   logic enc_step;
   logic enc_dir;

   clpr_quad_decoder u_quad (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .enc_a_i (enc_a_i),
      .enc_b_i (enc_b_i),
      .step_o  (enc_step),
      .dir_o   (enc_dir)
   );

   // -----------------------------------------------------------------
   // Encoder position in 32.16 microstep units
   // -----------------------------------------------------------------
   logic [47:0] enc_pos_q, enc_pos_d;
   logic [47:0] enc_inc;
   logic [16:0] frac;
   logic [31:0] ipart;

   always_comb begin
      frac  = 17'(enc_pos_q[15:0]);
      ipart = enc_pos_q[47:16];
      // Decimal mode carries the fraction at 10000 instead of 2^16.
      if (cfg_i.decimal_mode) begin
         enc_inc = 48'(cfg_i.enc_const[31:16]) << 16;
      end else begin
         enc_inc = 48'(cfg_i.enc_const);
      end
      enc_pos_d = enc_pos_q;
      if (enc_step) begin
         if (cfg_i.decimal_mode) begin
            if (enc_dir) begin
               frac  = frac + 17'(cfg_i.enc_const[15:0]);
               ipart = ipart + cfg_i.enc_const[31:16];
               if (frac >= 17'(clpr_pkg::DEC_DENOM)) begin
                  frac  = frac - 17'(clpr_pkg::DEC_DENOM);
                  ipart = ipart + 32'h1;
               end
            end else begin
               ipart = ipart - cfg_i.enc_const[31:16];
               if (frac < 17'(cfg_i.enc_const[15:0])) begin
                  frac  = frac + 17'(clpr_pkg::DEC_DENOM);
                  ipart = ipart - 32'h1;
               end
               frac = frac - 17'(cfg_i.enc_const[15:0]);
            end
            enc_pos_d = {ipart, frac[15:0]};
         end else begin
            enc_pos_d = enc_dir ? enc_pos_q + enc_inc : enc_pos_q - enc_inc;
         end
      end
   end

   // -----------------------------------------------------------------
   // Electrical angle: binary scaling only
   // -----------------------------------------------------------------
   logic [31:0] angle_q, angle_d;
   logic [ANGLE_W_L-1:0] ustep_q, ustep_d;
   logic [ANGLE_W_L-1:0] load_angle;
   logic                 la_exc_q, la_exc_d;

   always_comb begin
      angle_d = angle_q;
      // The scale is a plain binary multiple of encoder counts.
      if (angle_wr_i) begin
         angle_d = angle_wdata_i;
      end else if (enc_step) begin
         angle_d = enc_dir ? angle_q + cfg_i.vector_count_scale : angle_q - cfg_i.vector_count_scale;
      end
      ustep_d = ustep_q;
      if (seq_step_i) begin
         ustep_d = seq_dir_i ? ustep_q + 1'b1 : ustep_q - 1'b1;
      end
      // The difference wraps in 13 bits, so the magnitude is taken the short way round.
      load_angle = ANGLE_W_L'(ustep_q - angle_q[ANGLE_W_L+3:4]);
      load_angle = load_angle[ANGLE_W_L-1] ? ANGLE_W_L'(-load_angle) : load_angle;
      // Limit is free to exceed a quarter turn for field weakening.
      la_exc_d = cfg_i.enable && (load_angle > cfg_i.load_angle_limit);
   end

   // -----------------------------------------------------------------
   // Regulator
   // -----------------------------------------------------------------
   logic [31:0]  err_q, err_d, prev_err_q, prev_err_d;
   logic [31:0]  vel_q, vel_d, clip_q, clip_d;
   logic signed [ACC_W_L-1:0] isum_q, isum_d;
   logic [clpr_pkg::INT_DIV_W-1:0] icnt_q, icnt_d;
   logic [15:0]  ucnt_q, ucnt_d, dcnt_q, dcnt_d;
   logic [31:0]  dterm_q, dterm_d;
   logic         warn_q, warn_d;
   logic signed [ACC_W_L-1:0] pterm, iterm_sum, sum, iclip_s;
   logic [31:0]  raw_err, abs_err;

   always_comb begin
      raw_err = enc_pos_q[47:16] - seq_position_i;
      abs_err = abs32(raw_err);
      err_d   = raw_err;
      icnt_d  = icnt_q + 1'b1;
      // A counter at zero reloads, so updates come every update_div plus one cycles.
      ucnt_d  = (ucnt_q == 16'h0) ? cfg_i.update_div : ucnt_q - 16'h1;
      dcnt_d  = (dcnt_q == 16'h0) ? cfg_i.d_clk_div : dcnt_q - 16'h1;
      prev_err_d = prev_err_q;
      dterm_d    = dterm_q;
      if (dcnt_q == 16'h0) begin
         // Zero gain removes the term entirely.
         dterm_d    = 32'($signed(cfg_i.d_gain) * $signed(err_q - prev_err_q));
         prev_err_d = err_q;
      end
      // Clipping after each step keeps a long stall from winding the integral past the limit.
      iclip_s   = ACC_W_L'($signed({1'b0, cfg_i.i_clip}));
      iterm_sum = isum_q;
      isum_d    = isum_q;
      if (!cfg_i.enable) begin
         isum_d = '0;
      end else if (icnt_q == '1) begin
         iterm_sum = isum_q + ACC_W_L'($signed(cfg_i.i_gain) * $signed(err_q));
         if (iterm_sum > iclip_s) isum_d = iclip_s;
         else if (iterm_sum < -iclip_s) isum_d = -iclip_s;
         else isum_d = iterm_sum;
      end
      pterm = ACC_W_L'($signed(cfg_i.p_gain) * $signed(err_q));
      sum   = pterm + isum_q + ACC_W_L'($signed(dterm_q)) + ACC_W_L'($signed(cfg_i.host_velocity_offset));
      vel_d  = vel_q;
      clip_d = clip_q;
      if (!cfg_i.enable) begin
         vel_d  = 32'h0;
         clip_d = 32'h0;
      end else if (ucnt_q == 16'h0) begin
         // Holding the host offset inside the band stops the loop hunting around the target.
         if (abs32(err_q) <= cfg_i.tolerance) begin
            vel_d = cfg_i.host_velocity_offset;
         end else begin
            vel_d = sat32(sum);
         end
         clip_d = 32'(sum - ACC_W_L'($signed(sat32(sum))));
      end
      // The warning uses the fresh error, so it updates in the same cycle as the reported error.
      warn_d = cfg_i.enable && (abs_err > cfg_i.warn_dist);
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         enc_pos_q  <= 48'h0;
         angle_q    <= clpr_pkg::POS_RESET;
         ustep_q    <= '0;
         la_exc_q   <= 1'b0;
         err_q      <= 32'h0;
         prev_err_q <= 32'h0;
         vel_q      <= 32'h0;
         clip_q     <= 32'h0;
         isum_q     <= '0;
         icnt_q     <= '0;
         ucnt_q     <= 16'h0;
         dcnt_q     <= 16'h0;
         dterm_q    <= 32'h0;
         warn_q     <= 1'b0;
      end else begin
         enc_pos_q  <= enc_pos_d;
         angle_q    <= angle_d;
         ustep_q    <= ustep_d;
         la_exc_q   <= la_exc_d;
         err_q      <= err_d;
         prev_err_q <= prev_err_d;
         vel_q      <= vel_d;
         clip_q     <= clip_d;
         isum_q     <= isum_d;
         icnt_q     <= icnt_d;
         ucnt_q     <= ucnt_d;
         dcnt_q     <= dcnt_d;
         dterm_q    <= dterm_d;
         warn_q     <= warn_d;
      end
   end

   assign stat_o.error           = err_q;
   assign stat_o.velocity        = vel_q;
   assign stat_o.clipping_amount = clip_q;
   assign stat_o.enc_position    = enc_pos_q[47:16];
   assign stat_o.deviation_warn  = warn_q;
   assign electrical_angle_position_o = angle_q;
   assign microstep_index_o           = ustep_q;
   assign load_angle_exceeded_o       = la_exc_q;
endmodule

// ===== test/clpr_regulator_sva.sv
`timescale 1ns/100ps
// ---------------------------------------------
// Port checker for the regulator
// ---------------------------------------------
module clpr_regulator_sva (
   input wire logic                         clock_i,
   input wire logic                         rst_n_i,
   input wire clpr_pkg::clpr_cfg_s          cfg_i,
   input wire logic [31:0]                  seq_position_i,
   input wire logic                         seq_step_i,
   input wire logic                         seq_dir_i,
   input wire logic                         angle_wr_i,
   input wire logic [31:0]                  angle_wdata_i,
   input wire clpr_pkg::clpr_stat_s         stat_o,
   input wire logic [31:0]                  electrical_angle_position_o,
   input wire logic [clpr_pkg::ANGLE_W-1:0] microstep_index_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   logic [31:0] err_mag;
   assign err_mag = stat_o.error[31] ? -stat_o.error : stat_o.error;
   a_err_diff: assert property ($past(rst_n_i) |->
      stat_o.error == $past(stat_o.enc_position) - $past(seq_position_i))
      else $error("error is not encoder minus sequencer position");
   a_dis_vel: assert property (!cfg_i.enable [*2] |-> stat_o.velocity == 32'h0)
      else $error("velocity not zero while disabled");
   a_dis_clip: assert property (!cfg_i.enable [*2] |-> stat_o.clipping_amount == 32'h0)
      else $error("clipping not zero while disabled");
   a_dis_warn: assert property (!cfg_i.enable [*2] |-> !stat_o.deviation_warn)
      else $error("warning raised while disabled");
   a_idx_up: assert property (seq_step_i && seq_dir_i |=> microstep_index_o == $past(microstep_index_o) + 1'b1)
      else $error("index did not count up");
   a_idx_down: assert property (seq_step_i && !seq_dir_i |=> microstep_index_o == $past(microstep_index_o) - 1'b1)
      else $error("index did not count down");
   a_idx_hold: assert property (!seq_step_i |=> $stable(microstep_index_o))
      else $error("index moved without a step");
   a_angle_load: assert property (angle_wr_i |=> electrical_angle_position_o == $past(angle_wdata_i))
      else $error("angle position not loaded");
   a_warn_set: assert property ((cfg_i.enable && err_mag > cfg_i.warn_dist) [*3] |-> stat_o.deviation_warn)
      else $error("deviation warning missing");
   a_dead_band: assert property ((cfg_i.enable && err_mag <= cfg_i.tolerance
      && cfg_i.update_div <= 16'h6 && $stable(cfg_i.host_velocity_offset)) [*8]
      |-> stat_o.velocity == cfg_i.host_velocity_offset)
      else $error("velocity in deadband is not the host offset");
endmodule
bind clpr_regulator clpr_regulator_sva u_sva (.clock_i(clock_i), .rst_n_i(rst_n_i), .cfg_i(cfg_i),
   .seq_position_i(seq_position_i), .seq_step_i(seq_step_i), .seq_dir_i(seq_dir_i), .angle_wr_i(angle_wr_i),
   .angle_wdata_i(angle_wdata_i), .stat_o(stat_o), .electrical_angle_position_o(electrical_angle_position_o),
   .microstep_index_o(microstep_index_o));

// ===== test/clpr_enc_model.sv
`timescale 1ns/100ps
// ---------------------------------------------
// Quadrature encoder on the measurement side
// ---------------------------------------------
module clpr_enc_model (
   input  wire logic clock_i,
   output logic      enc_a_o,
   output logic      enc_b_o
);
   logic [1:0] phase = 2'h0;
   // Gray order 00, 01, 11, 10 counts forward, so only one pin changes per step.
   assign enc_a_o = phase[1];
   assign enc_b_o = phase[1] ^ phase[0];
   task automatic step(input bit fwd, input int gap);
      @(negedge clock_i);
      phase <= fwd ? phase + 2'h1 : phase - 2'h1;
      repeat (gap) @(negedge clock_i);
   endtask
   task automatic home();
      phase <= 2'h0;
   endtask
endmodule

// ===== test/clpr_regulator_tb.sv
`timescale 1ns/100ps
// ---------------------------------------------
// Self-checking bench for the regulator
// ---------------------------------------------
module clpr_regulator_tb;
   logic                         clock_i = 1'b0;
   logic                         rst_n_i = 1'b0;
   clpr_pkg::clpr_cfg_s          cfg = '0;
   logic [31:0]                  seq_pos = 32'h0;
   logic                         seq_step = 1'b0;
   logic                         seq_dir = 1'b0;
   logic                         ang_wr = 1'b0;
   logic [31:0]                  ang_data = 32'h0;
   clpr_pkg::clpr_stat_s         stat;
   logic [31:0]                  angle;
   logic [clpr_pkg::ANGLE_W-1:0] idx;
   logic                         enc_a;
   logic                         enc_b;
   logic                         la_exc;
   longint                       acc_sum;
   int                           fails = 0;
   int                           compares = 0;
   int                           ip, fp, den, m_idx;
   always #2 clock_i = ~clock_i;
   clpr_enc_model ENC (.clock_i(clock_i), .enc_a_o(enc_a), .enc_b_o(enc_b));
   clpr_regulator DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .enc_a_i(enc_a), .enc_b_i(enc_b), .cfg_i(cfg),
      .seq_position_i(seq_pos), .seq_step_i(seq_step), .seq_dir_i(seq_dir), .angle_wr_i(ang_wr),
      .angle_wdata_i(ang_data), .stat_o(stat), .electrical_angle_position_o(angle),
      .microstep_index_o(idx), .load_angle_exceeded_o(la_exc));
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic do_reset();
      rst_n_i = 1'b0;
      ENC.home();
      repeat (6) @(negedge clock_i);
      rst_n_i = 1'b1;
      ip = 0;
      fp = 0;
      m_idx = 0;
   endtask
   // The model keeps integer and fraction apart so both denominators share one carry rule.
   task automatic move(input bit fwd, input int n, input int gap);
      for (int k = 0; k < n; k++) begin
         ENC.step(fwd, gap);
         fp += fwd ? int'(cfg.enc_const[15:0]) : -int'(cfg.enc_const[15:0]);
         ip += fwd ? int'(cfg.enc_const[31:16]) : -int'(cfg.enc_const[31:16]);
         if (fp >= den) begin
            fp -= den;
            ip++;
         end else if (fp < 0) begin
            fp += den;
            ip--;
         end
      end
      repeat (8) @(negedge clock_i);
   endtask
   initial begin
      void'($urandom(86));
      cfg.update_div = 16'h3;
      cfg.vector_count_scale = 32'd1600;
      do_reset();
      check("enc_position", 32'h0, stat.enc_position);
      check("velocity", 32'h0, stat.velocity);
      check("angle", 32'h0, angle);
      check("index", 32'h0, {19'h0, idx});
      $display("test reset done");
      for (int mode = 0; mode < 2; mode++) begin
         cfg.decimal_mode = mode[0];
         den = mode ? 10000 : 65536;
         cfg.enc_const = {14'h0, 2'($urandom), 16'(mode ? $urandom_range(0, 9999) : $urandom)};
         do_reset();
         move(1'b1, 9, 4);
         move(1'b0, 3, 9);
         seq_pos = $urandom_range(0, 500);
         repeat (3) @(negedge clock_i);
         check("enc_position", ip, stat.enc_position);
         check("error", ip - seq_pos, stat.error);
         $display("test scaling mode %0d done", mode);
      end
      for (int k = 0; k < 12; k++) begin
         seq_dir = (k > 1) && (k % 4 != 3);
         seq_step = 1'b1;
         m_idx += seq_dir ? 1 : -1;
         @(negedge clock_i);
      end
      seq_step = 1'b0;
      repeat (3) @(negedge clock_i);
      check("index", {19'h0, 13'(m_idx)}, {19'h0, idx});
      ang_data = $urandom;
      ang_wr = 1'b1;
      @(negedge clock_i);
      ang_wr = 1'b0;
      repeat (2) @(negedge clock_i);
      check("angle", ang_data, angle);
      move(1'b1, 3, 4);
      check("angle", ang_data + 32'd4800, angle);
      $display("test index and angle done");
      seq_pos = 32'h100;
      repeat (20) @(negedge clock_i);
      check("velocity", 32'h0, stat.velocity);
      check("clipping", 32'h0, stat.clipping_amount);
      check("warn", 32'h0, {31'h0, stat.deviation_warn});
      do_reset();
      cfg.enable = 1'b1;
      cfg.tolerance = 32'd10;
      cfg.host_velocity_offset = $urandom_range(1, 1 << 20);
      seq_pos = 32'd5;
      repeat (20) @(negedge clock_i);
      check("velocity", cfg.host_velocity_offset, stat.velocity);
      check("clipping", 32'h0, stat.clipping_amount);
      cfg.tolerance = 32'h0;
      cfg.p_gain = 16'd3;
      cfg.warn_dist = 32'd50;
      seq_pos = 32'd100;
      repeat (20) @(negedge clock_i);
      check("error", -32'd100, stat.error);
      check("warn", 32'h1, {31'h0, stat.deviation_warn});
      check("velocity", cfg.host_velocity_offset - 32'd300, stat.velocity);
      cfg.warn_dist = 32'd200;
      repeat (20) @(negedge clock_i);
      check("warn", 32'h0, {31'h0, stat.deviation_warn});
      // Any 128 consecutive edges hold exactly one integration step.
      cfg.i_clip = 32'h7fff_ffff;
      cfg.i_gain = 16'd1;
      repeat (128) @(negedge clock_i);
      cfg.i_gain = 16'h0;
      repeat (8) @(negedge clock_i);
      check("velocity", cfg.host_velocity_offset - 32'd400, stat.velocity);
      cfg.i_clip = 32'd5000;
      cfg.i_gain = 16'd1000;
      repeat (260) @(negedge clock_i);
      check("velocity", cfg.host_velocity_offset - 32'd5300, stat.velocity);
      cfg.i_gain = 16'h0;
      cfg.p_gain = 16'h4000;
      seq_pos = 32'h0100_0000;
      repeat (20) @(negedge clock_i);
      acc_sum = longint'(cfg.host_velocity_offset) - 64'sd5000 - (64'sd1 <<< 38);
      check("velocity", 32'h8000_0001, stat.velocity);
      check("clipping", 32'(acc_sum + 64'sh7fff_ffff), stat.clipping_amount);
      ang_data = 32'h0000_a000;
      ang_wr = 1'b1;
      @(negedge clock_i);
      ang_wr = 1'b0;
      cfg.load_angle_limit = 13'h09ff;
      repeat (3) @(negedge clock_i);
      check("load_angle", 32'h1, {31'h0, la_exc});
      cfg.load_angle_limit = 13'h0a00;
      repeat (3) @(negedge clock_i);
      check("load_angle", 32'h0, {31'h0, la_exc});
      $display("test regulator done");
      complete_run();
   end
   // The tests take well under 2000 cycles, so ten times that marks a hang.
   initial begin
      #80000;
      fails++;
      complete_run();
   end
endmodule
